// >>> src/datapath_pkg.sv
package datapath_pkg;
// Functional notes
// - register-count shift takes signed amount from base register bits 5:0
// - negative amount shifts left, positive shifts right with sign copy
// - whole 40-bit accumulator shifted in place, shifted-out bits lost
// - amount above 16 or below -16 keeps accumulator and raises trap
// - accumulator result clipped when its control bit 7 or 6 enables it
// - accumulator shift touches only overflow and clipped accumulator flags
// - opcode C8 with accumulator bit, low nibble picks count register
// - file one-bit left shift: top bit to carry, zero into bit 0
// - destination bit 0 writes default register, 1 writes file register
// - byte/word bit 0 means 16-bit word, 1 means 8-bit byte
// - default working register is working register zero
// - literal and count shifts drop top bits, set only negative and zero
// - literal and count shifts are always 16-bit word operations
// - count shift uses count bits 4:0, counts above 15 give zero
// - file subtract: file minus default register, five arithmetic flags
// - file subtract holds 13-bit file address below dest and size bits
// - literal accumulator shift uses signed 6-bit literal, same checks
  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int AMT_W = 6;
  localparam int CNT_W = 5;
  localparam int SEL_W = 4;
  localparam int MODE_W = 3;
  localparam int FADDR_W = 13;
  localparam int INSN_W = 24;
  localparam int GUARD_W = 16;
  localparam int ACC_OVF_LSB = 31;
  localparam int CTRL_W = 16;
  localparam int CTRL_FIRST_CLIP = 7;
  localparam int CTRL_SECOND_CLIP = 6;
  localparam logic signed [5:0] ACC_AMT_MAX = 6'sh10;
  localparam logic signed [5:0] ACC_AMT_MIN = 6'sh30;
  localparam logic [4:0] WNS_CNT_MAX = 5'h0F;
  localparam logic [7:0] OP_ACC_SHIFT = 8'hC8;
  localparam logic [6:0] ACC_PAD = 7'h00;
  localparam logic [3:0] ACC_REG_TAG = 4'h0;
  localparam logic [1:0] ACC_LIT_TAG = 2'h1;
  localparam logic [8:0] OP_SL_FILE = 9'h1A8;
  localparam logic [8:0] OP_SL_WORK = 9'h1A0;
  localparam logic [8:0] OP_SL_SHORT = 9'h1BA;
  localparam logic [2:0] SHORT_LIT_TAG = 3'h4;
  localparam logic [2:0] SHORT_REG_TAG = 3'h0;
  localparam logic [8:0] OP_SUB_FILE = 9'h16A;
  localparam int POS_ACC_SEL = 15;
  localparam int POS_BYTE = 14;
  localparam int POS_DEST = 13;
  localparam int POS_BASE = 11;
  localparam int POS_DMODE = 11;
  localparam int POS_DREG = 7;
  localparam int POS_SMODE = 4;
  localparam logic [2:0] MODE_DIRECT = 3'h0;
  localparam logic [3:0] WORK_ZERO = 4'h0;
  localparam logic [39:0] SAT_POS = 40'h7F_FFFF_FFFF;
  localparam logic [39:0] SAT_NEG = 40'h80_0000_0000;
  typedef enum logic [2:0] {
    WOP_SL1 = 3'b001,
    WOP_SLN = 3'b010,
    WOP_SUB = 3'b100
  } word_op_t;
  typedef enum logic [5:0] {
    INS_NONE = 6'b000001,
    INS_ACC = 6'b000010,
    INS_SL_FILE = 6'b000100,
    INS_SL_WORK = 6'b001000,
    INS_SL_MULTI = 6'b010000,
    INS_SUB = 6'b100000
  } insn_t;
endpackage : datapath_pkg

// >>> src/exec_bus_if.sv
`timescale 1ns/1ns
interface exec_bus_if;
  logic [datapath_pkg::ACC_W-1:0] acc_in;
  logic [datapath_pkg::AMT_W-1:0] acc_amt;
  logic clip_en;
  logic [datapath_pkg::ACC_W-1:0] acc_out;
  logic acc_ovf;
  logic acc_clip;
  logic amt_bad;
  datapath_pkg::word_op_t word_op;
  logic byte_op;
  logic [datapath_pkg::WORD_W-1:0] opa;
  logic [datapath_pkg::WORD_W-1:0] opb;
  logic [datapath_pkg::CNT_W-1:0] count;
  logic [datapath_pkg::WORD_W-1:0] result;
  logic fc;
  logic fn;
  logic fz;
  logic fov;
  logic fdc;
  modport core (
    output acc_in, acc_amt, clip_en, word_op, byte_op, opa, opb, count,
    input acc_out, acc_ovf, acc_clip, amt_bad, result, fc, fn, fz, fov, fdc
  );
  modport acc_unit (
    input acc_in, acc_amt, clip_en,
    output acc_out, acc_ovf, acc_clip, amt_bad
  );
  modport word_unit (
    input word_op, byte_op, opa, opb, count,
    output result, fc, fn, fz, fov, fdc
  );
endinterface : exec_bus_if

// >>> src/acc_shift_unit.sv
`timescale 1ns/1ns
module acc_shift_unit (
  exec_bus_if.acc_unit bus
);
  localparam int EXT_W = datapath_pkg::ACC_W + datapath_pkg::GUARD_W;
  localparam int AW = datapath_pkg::ACC_W;
  wire signed [datapath_pkg::AMT_W-1:0] amt = bus.acc_amt;
  wire signed [AW-1:0] acc = bus.acc_in;
  wire go_left = amt[datapath_pkg::AMT_W-1];
  wire [datapath_pkg::AMT_W-1:0] mag = go_left ? -amt : amt;
  wire signed [EXT_W-1:0] ext = {{datapath_pkg::GUARD_W{acc[AW-1]}}, acc};
  wire signed [EXT_W-1:0] ext_left = ext <<< mag;
  wire [EXT_W-AW:0] spill = ext_left[EXT_W-1:AW-1];
  wire lost = go_left && !((&spill) || !(|spill));
  wire [AW-1:0] raw = go_left ? ext_left[AW-1:0] : AW'(acc >>> mag);
  wire [AW-1:0] sat = acc[AW-1] ? datapath_pkg::SAT_NEG
                                : datapath_pkg::SAT_POS;
  // result bits that must all agree when no overflow happened
  wire [AW-datapath_pkg::ACC_OVF_LSB-1:0] top =
      bus.acc_out[AW-1:datapath_pkg::ACC_OVF_LSB];

  // range check on the signed amount
  assign bus.amt_bad = (amt > datapath_pkg::ACC_AMT_MAX) ||
                       (amt < datapath_pkg::ACC_AMT_MIN);
  // clip to full scale of the input sign when enabled and a left shift loses bits
  assign bus.acc_clip = lost && bus.clip_en;
  assign bus.acc_out = bus.acc_clip ? sat : raw;
  // overflow past bit 31 into the guard bits
  assign bus.acc_ovf = !((&top) || !(|top));
endmodule : acc_shift_unit

// >>> src/word_alu_unit.sv
`timescale 1ns/1ns
module word_alu_unit (
  exec_bus_if.word_unit bus
);
  localparam int WW = datapath_pkg::WORD_W;
  localparam int BW = datapath_pkg::BYTE_W;
  wire [WW-1:0] a = bus.opa;
  wire [WW-1:0] b = bus.opb;
  wire bm = bus.byte_op;
  wire [WW:0] wide = {1'b0, a} - {1'b0, b};
  wire [BW:0] low = {1'b0, a[BW-1:0]} - {1'b0, b[BW-1:0]};
  wire [4:0] nib = {1'b0, a[3:0]} - {1'b0, b[3:0]};
  wire [WW-1:0] sl1 = bm ? {a[WW-1:BW], a[BW-2:0], 1'b0} : {a[WW-2:0], 1'b0};
  wire [WW-1:0] sln = (bus.count > datapath_pkg::WNS_CNT_MAX) ? '0 :
                      a << bus.count[3:0];
  wire [WW-1:0] sub = bm ? {a[WW-1:BW], low[BW-1:0]} : wide[WW-1:0];

  // top bit of the operand size in use
  function automatic logic msb_of(input logic [WW-1:0] v, input logic bsel);
    msb_of = bsel ? v[BW-1] : v[WW-1];
  endfunction : msb_of

  // zero test over the operand size in use
  function automatic logic zero_of(input logic [WW-1:0] v, input logic bsel);
    zero_of = bsel ? (v[BW-1:0] == '0) : (v == '0);
  endfunction : zero_of

  // result and flag selection per operation
  always_comb begin
    bus.result = sub;
    bus.fc = bm ? ~low[BW] : ~wide[WW];
    bus.fdc = bm ? ~nib[4] : ~low[BW];
    bus.fov = (msb_of(a, bm) != msb_of(b, bm)) &&
              (msb_of(sub, bm) != msb_of(a, bm));
    case (bus.word_op)
      datapath_pkg::WOP_SL1: begin
        bus.result = sl1;
        bus.fc = msb_of(a, bm);
      end
      datapath_pkg::WOP_SLN: bus.result = sln;
      datapath_pkg::WOP_SUB: bus.result = sub;
      default: bus.result = sub;
    endcase
    bus.fn = msb_of(bus.result, bm);
    bus.fz = zero_of(bus.result, bm);
  end
endmodule : word_alu_unit

// >>> src/shift_subtract_datapath.sv
`timescale 1ns/1ns
module shift_subtract_datapath #(
  parameter int ACC_WIDTH = datapath_pkg::ACC_W,
  parameter int WORD_WIDTH = datapath_pkg::WORD_W
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [datapath_pkg::INSN_W-1:0] instr_word,
  input wire logic [datapath_pkg::CTRL_W-1:0] core_control_reg,
  input wire logic [WORD_WIDTH-1:0] file_data,
  input wire logic [WORD_WIDTH-1:0] default_work_register,
  input wire logic [WORD_WIDTH-1:0] source_register,
  input wire logic [WORD_WIDTH-1:0] base_register,
  input wire logic clip_flags_clear,
  output logic [datapath_pkg::SEL_W-1:0] source_sel,
  output logic [datapath_pkg::MODE_W-1:0] source_mode,
  output logic [datapath_pkg::SEL_W-1:0] base_sel,
  output logic wb_valid,
  output logic wb_to_file,
  output logic [datapath_pkg::FADDR_W-1:0] wb_file_addr,
  output logic [datapath_pkg::SEL_W-1:0] dest_register,
  output logic [datapath_pkg::MODE_W-1:0] dest_mode,
  output logic wb_byte,
  output logic [WORD_WIDTH-1:0] wb_data,
  output logic [ACC_WIDTH-1:0] first_accumulator,
  output logic [ACC_WIDTH-1:0] second_accumulator,
  output logic carry,
  output logic negative,
  output logic zero,
  output logic overflow,
  output logic digit_carry,
  output logic first_acc_overflow,
  output logic second_acc_overflow,
  output logic either_acc_overflow,
  output logic first_acc_clipped,
  output logic second_acc_clipped,
  output logic either_acc_clipped,
  output logic arith_trap
);
  // the shift and flag units are built for the documented widths only
  if (ACC_WIDTH != datapath_pkg::ACC_W ||
      WORD_WIDTH != datapath_pkg::WORD_W) begin : g_bad_width
    $error("unsupported accumulator or word width");
  end

  exec_bus_if bus ();

  acc_shift_unit u_acc (
    .bus(bus.acc_unit)
  );

  word_alu_unit u_word (
    .bus(bus.word_unit)
  );

  // opcode field slices
  wire [8:0] op9 = instr_word[23:15];
  wire [7:0] op8 = instr_word[23:16];
  wire [2:0] tag3 = instr_word[6:4];
  wire acc_pick = instr_word[datapath_pkg::POS_ACC_SEL];
  wire byte_bit = instr_word[datapath_pkg::POS_BYTE];
  wire dest_bit = instr_word[datapath_pkg::POS_DEST];
  wire [datapath_pkg::SEL_W-1:0] f_base = instr_word[14:11];
  wire [datapath_pkg::SEL_W-1:0] f_dreg = instr_word[10:7];
  wire [datapath_pkg::MODE_W-1:0] f_dmode = instr_word[13:11];
  wire [datapath_pkg::MODE_W-1:0] f_smode = instr_word[6:4];
  wire [datapath_pkg::SEL_W-1:0] f_sreg = instr_word[3:0];
  wire [datapath_pkg::FADDR_W-1:0] f_addr = instr_word[12:0];
  wire [datapath_pkg::AMT_W-1:0] f_slit = instr_word[5:0];

  // instruction recognition
  wire acc_head = (op8 == datapath_pkg::OP_ACC_SHIFT) &&
                  (instr_word[14:8] == datapath_pkg::ACC_PAD);
  wire acc_reg = acc_head &&
                 (instr_word[7:4] == datapath_pkg::ACC_REG_TAG);
  wire acc_lit = acc_head &&
                 (instr_word[7:6] == datapath_pkg::ACC_LIT_TAG);
  wire is_sl_file = (op9 == datapath_pkg::OP_SL_FILE);
  wire is_sl_work = (op9 == datapath_pkg::OP_SL_WORK);
  wire short_head = (op9 == datapath_pkg::OP_SL_SHORT);
  wire is_sl_lit = short_head && (tag3 == datapath_pkg::SHORT_LIT_TAG);
  wire is_sl_wns = short_head && (tag3 == datapath_pkg::SHORT_REG_TAG);
  wire is_sub = (op9 == datapath_pkg::OP_SUB_FILE);

  // one-hot instruction class, none when no valid word is offered
  datapath_pkg::insn_t kind;
  always_comb begin
    kind = datapath_pkg::INS_NONE;
    if (instr_valid) begin
      if (acc_reg || acc_lit)
        kind = datapath_pkg::INS_ACC;
      else if (is_sl_file)
        kind = datapath_pkg::INS_SL_FILE;
      else if (is_sl_work)
        kind = datapath_pkg::INS_SL_WORK;
      else if (is_sl_lit || is_sl_wns)
        kind = datapath_pkg::INS_SL_MULTI;
      else if (is_sub)
        kind = datapath_pkg::INS_SUB;
    end
  end

  // register read selection towards the register file
  assign source_sel = short_head ? f_base : f_sreg;
  assign source_mode = is_sl_work ? f_smode : datapath_pkg::MODE_DIRECT;
  assign base_sel = f_sreg; // count register for both register-count forms

  // accumulator unit operands
  wire [ACC_WIDTH-1:0] acc_cur = acc_pick ? second_accumulator
                                          : first_accumulator;
  wire clip_first = core_control_reg[datapath_pkg::CTRL_FIRST_CLIP];
  wire clip_second = core_control_reg[datapath_pkg::CTRL_SECOND_CLIP];
  assign bus.acc_in = acc_cur;
  assign bus.acc_amt = acc_lit ? f_slit :
      base_register[datapath_pkg::AMT_W-1:0];
  assign bus.clip_en = acc_pick ? clip_second : clip_first;

  // word unit operands
  wire file_form = is_sl_file || is_sub;
  wire multi_form = is_sl_lit || is_sl_wns;
  assign bus.word_op = is_sub ? datapath_pkg::WOP_SUB :
                       multi_form ? datapath_pkg::WOP_SLN
                                  : datapath_pkg::WOP_SL1;
  assign bus.byte_op = multi_form ? 1'b0 : byte_bit;
  assign bus.opa = file_form ? file_data : source_register;
  assign bus.opb = default_work_register;
  assign bus.count = is_sl_lit ? {1'b0, f_sreg} :
      base_register[datapath_pkg::CNT_W-1:0];

  // write-back target decode
  wire take_acc = (kind == datapath_pkg::INS_ACC);
  wire acc_ok = take_acc && !bus.amt_bad;
  wire word_wr = (kind == datapath_pkg::INS_SL_FILE) ||
                 (kind == datapath_pkg::INS_SL_WORK) ||
                 (kind == datapath_pkg::INS_SL_MULTI) ||
                 (kind == datapath_pkg::INS_SUB);
  wire next_to_file = file_form && dest_bit;
  wire [datapath_pkg::SEL_W-1:0] next_dreg =
      file_form ? datapath_pkg::WORK_ZERO : f_dreg;
  wire [datapath_pkg::MODE_W-1:0] next_dmode =
      is_sl_work ? f_dmode : datapath_pkg::MODE_DIRECT;
  wire next_byte = bus.byte_op;

  // flag update enables per class
  wire upd_c = (kind == datapath_pkg::INS_SL_FILE) ||
               (kind == datapath_pkg::INS_SL_WORK) ||
               (kind == datapath_pkg::INS_SUB);
  wire upd_nz = word_wr;
  wire upd_arith = (kind == datapath_pkg::INS_SUB);
  wire next_carry = upd_c ? bus.fc : carry;
  wire next_negative = upd_nz ? bus.fn : negative;
  wire next_zero = upd_nz ? bus.fz : zero;
  wire next_overflow = upd_arith ? bus.fov : overflow;
  wire next_digit_carry = upd_arith ? bus.fdc : digit_carry;

  // accumulator flag updates, only for the accumulator written
  wire hit_first = acc_ok && !acc_pick;
  wire hit_second = acc_ok && acc_pick;
  wire next_first_ovf = hit_first ? bus.acc_ovf : first_acc_overflow;
  wire next_second_ovf = hit_second ? bus.acc_ovf : second_acc_overflow;
  wire set_first_clip = hit_first && bus.acc_clip;
  wire set_second_clip = hit_second && bus.acc_clip;
  // a new clip event wins over a simultaneous clear
  wire next_first_clip = set_first_clip ||
                         (first_acc_clipped && !clip_flags_clear);
  wire next_second_clip = set_second_clip ||
                          (second_acc_clipped && !clip_flags_clear);

  // accumulator storage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_accumulator <= '0;
      second_accumulator <= '0;
    end else begin
      if (hit_first)
        first_accumulator <= bus.acc_out;
      if (hit_second)
        second_accumulator <= bus.acc_out;
    end
  end

  // accumulator flags and trap pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_acc_overflow <= 1'b0;
      second_acc_overflow <= 1'b0;
      first_acc_clipped <= 1'b0;
      second_acc_clipped <= 1'b0;
      arith_trap <= 1'b0;
    end else begin
      first_acc_overflow <= next_first_ovf;
      second_acc_overflow <= next_second_ovf;
      first_acc_clipped <= next_first_clip;
      second_acc_clipped <= next_second_clip;
      arith_trap <= take_acc && bus.amt_bad;
    end
  end

  // combined accumulator flags
  assign either_acc_overflow = first_acc_overflow || second_acc_overflow;
  assign either_acc_clipped = first_acc_clipped || second_acc_clipped;

  // arithmetic status flags
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      carry <= 1'b0;
      negative <= 1'b0;
      zero <= 1'b0;
      overflow <= 1'b0;
      digit_carry <= 1'b0;
    end else begin
      carry <= next_carry;
      negative <= next_negative;
      zero <= next_zero;
      overflow <= next_overflow;
      digit_carry <= next_digit_carry;
    end
  end

  // write-back strobe and target
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_valid <= 1'b0;
      wb_to_file <= 1'b0;
      wb_file_addr <= '0;
      dest_register <= '0;
      dest_mode <= '0;
      wb_byte <= 1'b0;
    end else begin
      wb_valid <= word_wr;
      wb_to_file <= next_to_file;
      wb_file_addr <= f_addr;
      dest_register <= next_dreg;
      dest_mode <= next_dmode;
      wb_byte <= next_byte;
    end
  end

  // write-back data
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      wb_data <= '0;
    else if (word_wr)
      wb_data <= bus.result;
  end
endmodule : shift_subtract_datapath

// >>> verif/ssd_properties.sv
`timescale 1ns/1ns
module ssd_properties #(
  parameter int ACC_WIDTH = 40,
  parameter int WORD_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic [WORD_WIDTH-1:0] file_data,
  input wire logic [WORD_WIDTH-1:0] default_work_register,
  input wire logic [WORD_WIDTH-1:0] base_register,
  input wire logic wb_valid,
  input wire logic wb_to_file,
  input wire logic wb_byte,
  input wire logic [3:0] dest_register,
  input wire logic [WORD_WIDTH-1:0] wb_data,
  input wire logic [ACC_WIDTH-1:0] first_accumulator,
  input wire logic [ACC_WIDTH-1:0] second_accumulator,
  input wire logic carry,
  input wire logic zero,
  input wire logic arith_trap
);
  // instruction decode seen from the pins
  wire logic [8:0] op = instr_word[23:15];
  wire logic acc = instr_valid && instr_word[23:16] == 8'hC8
    && instr_word[14:8] == 7'h00;
  wire logic acc_l = acc && instr_word[7:6] == 2'h1;
  wire logic acc_r = acc && instr_word[7:4] == 4'h0;
  wire logic signed [5:0] la = instr_word[5:0];
  wire logic signed [5:0] ra = base_register[5:0];
  wire logic bad_l = la > 6'sh10 || la < 6'sh30;
  wire logic bad_r = ra > 6'sh10 || ra < 6'sh30;
  wire logic sl_f = instr_valid && op == 9'h1A8;
  wire logic sub_f = instr_valid && op == 9'h16A;
  wire logic sl_n = instr_valid && op == 9'h1BA;
  wire logic cnt = sl_n && instr_word[6:4] == 3'h0;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_lit_trap;
    acc_l && bad_l |=> arith_trap;
  endproperty
  a_lit_trap: assert property (p_lit_trap)
    else $error("literal shift out of range gave no trap");
  property p_reg_trap;
    acc_r && bad_r |=> arith_trap && $stable(first_accumulator)
      && $stable(second_accumulator);
  endproperty
  a_reg_trap: assert property (p_reg_trap)
    else $error("register shift out of range not refused");
  property p_ok_no_trap;
    (acc_l && !bad_l) || (acc_r && !bad_r) |=> !arith_trap && !wb_valid;
  endproperty
  a_ok_no_trap: assert property (p_ok_no_trap)
    else $error("legal accumulator shift trapped or wrote a word");
  property p_trap_cause;
    arith_trap |-> $past(acc);
  endproperty
  a_trap_cause: assert property (p_trap_cause)
    else $error("trap without accumulator shift");
  property p_file_shift;
    sl_f && !instr_word[14] |=> wb_data == ($past(file_data) << 1)
      && {15'h0000, carry} == ($past(file_data) >> 15);
  endproperty
  a_file_shift: assert property (p_file_shift)
    else $error("file word shift result or carry wrong");
  property p_file_dest;
    (sl_f || sub_f) && !instr_word[13] |=> wb_valid && !wb_to_file
      && dest_register == 4'h0;
  endproperty
  a_file_dest: assert property (p_file_dest)
    else $error("file form did not write working register zero");
  property p_sub;
    sub_f && !instr_word[14] |=> wb_data == $past(file_data)
      - $past(default_work_register) && carry == ($past(file_data)
      >= $past(default_work_register));
  endproperty
  a_sub: assert property (p_sub)
    else $error("file subtract result or carry wrong");
  property p_cnt_zero;
    cnt && base_register[4:0] > 5'h0F |=> wb_data == 16'h0000 && zero;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero)
    else $error("count above 15 did not give zero");
  property p_short_c;
    sl_n |=> $stable(carry) && wb_valid && !wb_byte;
  endproperty
  a_short_c: assert property (p_short_c)
    else $error("multi-bit shift touched carry or was not a word");
  property p_wb_cause;
    wb_valid |-> $past(instr_valid);
  endproperty
  a_wb_cause: assert property (p_wb_cause)
    else $error("write-back without an instruction");
  c_trap: cover property (arith_trap);
  c_sub: cover property (sub_f);
  c_cnt: cover property (cnt && base_register[4:0] > 5'h0F);
endmodule : ssd_properties
bind shift_subtract_datapath ssd_properties #(
  .ACC_WIDTH(ACC_WIDTH), .WORD_WIDTH(WORD_WIDTH)
) i_props (.sys_clk, .nrst, .instr_valid, .instr_word, .file_data,
  .default_work_register, .base_register, .wb_valid, .wb_to_file,
  .wb_byte, .dest_register, .wb_data, .first_accumulator,
  .second_accumulator, .carry, .zero, .arith_trap);

// >>> verif/reg_file_model.sv
`timescale 1ns/1ns
module reg_file_model (
  input wire logic sys_clk,
  input wire logic [23:0] instr_word,
  input wire logic [3:0] source_sel,
  input wire logic [3:0] base_sel,
  input wire logic wb_valid,
  input wire logic wb_to_file,
  input wire logic [12:0] wb_file_addr,
  input wire logic [3:0] dest_register,
  input wire logic [15:0] wb_data,
  output logic [15:0] file_data,
  output logic [15:0] default_work_register,
  output logic [15:0] source_register,
  output logic [15:0] base_register
);
  logic [15:0] regs [16];
  logic [15:0] mem [16];
  // operands answer the selects in the same cycle
  assign file_data = mem[instr_word[3:0]];
  assign default_work_register = regs[0];
  assign source_register = regs[source_sel];
  assign base_register = regs[base_sel];
  // write-back lands on the edge that shows the pulse
  always @(posedge sys_clk) begin
    if (wb_valid && wb_to_file) begin
      mem[wb_file_addr[3:0]] <= wb_data;
    end else if (wb_valid) begin
      regs[dest_register] <= wb_data;
    end
  end
endmodule : reg_file_model

// >>> verif/tb_shift_subtract_datapath.sv
`timescale 1ns/1ns
module tb_shift_subtract_datapath;
  typedef struct packed {
    logic [23:0] ins;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] res;
    logic [5:0] dst;
    logic [4:0] flg;
  } row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic instr_valid = 1'b0;
  logic [23:0] instr_word = 24'h000000;
  logic [15:0] core_control_reg = 16'h0000;
  logic clip_flags_clear = 1'b0;
  logic [15:0] file_data, default_work_register, source_register;
  logic [15:0] base_register, wb_data;
  logic [3:0] source_sel, base_sel, dest_register;
  logic [12:0] wb_file_addr;
  logic [2:0] source_mode, dest_mode;
  logic [39:0] first_accumulator, second_accumulator;
  logic wb_valid, wb_to_file, wb_byte, carry, negative, zero;
  logic overflow, digit_carry, first_acc_overflow, second_acc_overflow;
  logic either_acc_overflow, first_acc_clipped, second_acc_clipped;
  logic either_acc_clipped, arith_trap;
  int miscompares = 0;
  int n_checks = 0;
  // ins, operand, W0 and count, result, byte/file/dest, C N Z OV DC
  row_t rows [12] = '{
    '{24'hD47FF1, 16'h4065, 16'h0000, 16'h40CA, 6'h30, 5'h08},
    '{24'hD40001, 16'h800F, 16'h0000, 16'h001E, 6'h00, 5'h10},
    '{24'hD04201, 16'h78A9, 16'h0000, 16'h7852, 6'h24, 5'h10},
    '{24'hDD0944, 16'h78A9, 16'h0000, 16'h8A90, 6'h02, 5'h18},
    '{24'hDD094F, 16'h0001, 16'h0000, 16'h8000, 6'h02, 5'h18},
    '{24'hDD0902, 16'h09A4, 16'h8903, 16'h4D20, 6'h02, 5'h10},
    '{24'hDD0902, 16'h09A4, 16'h0010, 16'h0000, 6'h02, 5'h14},
    '{24'hDD0902, 16'h0003, 16'h000F, 16'h8000, 6'h02, 5'h18},
    '{24'hB50001, 16'h4523, 16'h6234, 16'hE2EF, 6'h00, 5'h08},
    '{24'hB57FFF, 16'h3994, 16'h7804, 16'h3990, 6'h30, 5'h19},
    '{24'hB50001, 16'h1234, 16'h1234, 16'h0000, 6'h00, 5'h15},
    '{24'hB50001, 16'h8000, 16'h0001, 16'h7FFF, 6'h00, 5'h12}
  };
  // accumulator shift, count register value, trap expected
  logic [40:0] accs [9] = '{{24'hC80002, 16'h0011, 1'b1},
    {24'hC80002, 16'h0010, 1'b0}, {24'hC88002, 16'h0030, 1'b0},
    {24'hC88002, 16'h002F, 1'b1}, {24'hC80002, 16'hFF50, 1'b0},
    {24'hC80051, 16'h0000, 1'b1}, {24'hC88050, 16'h0000, 1'b0},
    {24'hC8806F, 16'h0000, 1'b1}, {24'hC88070, 16'h0000, 1'b0}};
  shift_subtract_datapath i_dut (.sys_clk, .nrst, .instr_valid,
    .instr_word, .core_control_reg, .file_data, .default_work_register,
    .source_register, .base_register, .clip_flags_clear, .source_sel,
    .source_mode, .base_sel, .wb_valid, .wb_to_file, .wb_file_addr,
    .dest_register, .dest_mode, .wb_byte, .wb_data, .first_accumulator,
    .second_accumulator, .carry, .negative, .zero, .overflow, .digit_carry,
    .first_acc_overflow, .second_acc_overflow, .either_acc_overflow,
    .first_acc_clipped, .second_acc_clipped, .either_acc_clipped,
    .arith_trap);
  reg_file_model i_partner (.sys_clk, .instr_word, .source_sel, .base_sel,
    .wb_valid, .wb_to_file, .wb_file_addr, .dest_register, .wb_data,
    .file_data, .default_work_register, .source_register, .base_register);
  // free-running clock
  always #10 sys_clk = ~sys_clk;
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  // watchdog well past the few dozen cycles the tests need
  initial begin
    #40000;
    miscompares++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    instr_valid = 1'b1;
    foreach (rows[i]) begin
      instr_word = rows[i].ins;
      i_partner.regs[0] = rows[i].b;
      i_partner.regs[1] = rows[i].a;
      i_partner.regs[2] = rows[i].b;
      i_partner.mem[rows[i].ins[3:0]] = rows[i].a;
      step();
      check(wb_valid, 1'b1);
      check(wb_data, rows[i].res);
      check({wb_byte, wb_to_file, dest_register}, rows[i].dst);
      check({carry, negative, zero, overflow, digit_carry},
        rows[i].flg);
      if (rows[i].dst[4]) begin
        check(wb_file_addr, rows[i].ins[12:0]);
      end
    end
    $display("test rows done");
    instr_valid = 1'b0;
    step();
    check(wb_valid, 1'b0);
    instr_valid = 1'b1;
    instr_word = 24'hFFFFFF;
    step();
    check({wb_valid, arith_trap}, 2'h0);
    $display("test idle and unknown done");
    instr_word = 24'hD00AA3;
    i_partner.regs[3] = 16'h4001;
    step();
    check({source_sel, source_mode}, {4'h3, 3'h2});
    check({dest_mode, dest_register, wb_data}, {3'h1, 4'h5, 16'h8002});
    check({wb_byte, wb_to_file, carry, negative, zero}, 5'h02);
    $display("test indirect shift done");
    core_control_reg = 16'h00C0;
    foreach (accs[i]) begin
      instr_word = accs[i][40:17];
      i_partner.regs[2] = accs[i][16:1];
      clip_flags_clear = ~clip_flags_clear;
      step();
      check(base_sel, instr_word[3:0]);
      check(arith_trap, accs[i][0]);
      check(first_accumulator | second_accumulator, 40'h0);
      check({wb_valid, either_acc_overflow, either_acc_clipped},
        3'h0);
    end
    $display("test accumulator shifts done");
    instr_word = 24'hD40001;
    i_partner.mem[1] = 16'h8001;
    step();
    check(carry, 1'b1);
    nrst = 1'b0;
    #1;
    check({wb_valid, carry, wb_data}, 18'h00000);
    step();
    nrst = 1'b1;
    instr_valid = 1'b0;
    step();
    check(first_accumulator, 40'h0);
    $display("test reset done");
    conclude();
  end
endmodule : tb_shift_subtract_datapath
